/* sideband_defines.vh */
// Purpose: Constants for the display sideband and strap block
// Assumes: 40 MHz core clock, register port with 4-bit word addresses
// Notes:   Offsets are word indices on the plain register port
`ifndef SIDEBAND_DEFINES_VH
`define SIDEBAND_DEFINES_VH
`define ADDR_W            4
`define OFS_STRAP         4'h0
`define OFS_STATUS        4'h1
`define OFS_IRQ_STAT      4'h2
`define OFS_IRQ_MASK      4'h3
`define OFS_THERM_CFG     4'h4
`define OFS_SPREAD_CTL    4'h5
`define OFS_CHAN_OUT      4'h6
`define OFS_CHAN_IN       4'h7
`define EV_HOTPLUG        0
`define EV_THERMAL        1
`define EV_W              2
`define MSG_SYSERR        2'h0
`define MSG_CTLIRQ        2'h1
`define MSG_MGMTIRQ       2'h2
`define THERM_EN_BIT      2
`define MASK_RESET        2'h0
`define THERM_CFG_RESET   3'h0
`define STRAP_SYNC_RESET  8'h00
`define MISC_SYNC_RESET   5'h03
`define LINE_SYNC_RESET   8'hff
`endif

/* display_sideband_strap_logic.v */
// Purpose: Display sideband pins, straps, hot-plug and thermal events
// Assumes: Pins synchronous enough to pass two flops; one core clock
// Notes:   Open-drain lines drive only low; released lines read high
// Overview of operation
// - Device-present strap sampled low means a video output device is attached.
// - Strap bit 0 high selects native graphic mode; low selects nothing.
// - The eight-bit identification strap is readable by firmware.
// - Thermal input is active low; assertion starts a memory read throttle.
// - If enabled, thermal trigger sends one selected message to the I/O hub.
// - Control bus and both monitor channels are released during hard reset.
// - Active-low hot-plug input assertion is registered as an interrupt event.
// - Active-low primary reset is the main reset.
// - No normal operation while power-good is low.
// - Two outputs control an external spread-spectrum clock generator.
// - Analog monitor channel uses shared open clock and data lines.
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "sideband_defines.vh"
`default_nettype none
module display_sideband_strap_logic (
  // Clock and resets
  input  wire                I_MCLK,
  input  wire                I_RESET_N,
  input  wire                I_PRIMARY_RESET_N,
  input  wire                I_POWER_GOOD,
  // Register port
  input  wire [`ADDR_W-1:0]  I_ADDR,
  input  wire [7:0]          I_WDATA,
  input  wire                I_WR,
  input  wire                I_RD,
  output reg  [7:0]          O_RDATA,
  // Straps and events
  input  wire [7:0]          I_ADDIN_IDENT_STRAP,
  input  wire                I_VIDEO_DEVICE_PRESENT_N,
  input  wire                I_DISPLAY_HOTPLUG_IRQ_N,
  input  wire                I_EXT_THERMAL_ALERT_N,
  // Results
  output reg                 O_IRQ,
  output reg                 O_READ_THROTTLE,
  output reg                 O_NATIVE_GFX_MODE,
  output reg                 O_SYSTEM_ERROR_MSG,
  output reg                 O_CONTROL_IRQ_MSG,
  output reg                 O_MANAGEMENT_IRQ_MSG,
  // Spread-spectrum clock chip
  output reg                 O_SPREAD_CLK_CTL,
  output reg                 O_SPREAD_DATA_CTL,
  // Open-drain lines: index 0 analog, 1 encoder bus, 2 primary, 3 second monitor
  input  wire [3:0]          I_CHAN_CLK,
  input  wire [3:0]          I_CHAN_DAT,
  output reg  [3:0]          O_CHAN_CLK,
  output reg  [3:0]          O_CHAN_DAT,
  output reg  [3:0]          O_CHAN_CLK_OE,
  output reg  [3:0]          O_CHAN_DAT_OE
);

  wire [7:0]             strap_sync;
  wire [4:0]             misc_sync;
  wire [7:0]             chin_sync;
  reg  [7:0]             ident_reg;
  reg                    present_reg;
  reg                    latched_reg;
  reg                    hotplug_q_reg;
  reg                    therm_q_reg;
  reg  [`EV_W-1:0]       irq_stat_reg;
  reg  [`EV_W-1:0]       irq_mask_reg;
  reg  [2:0]             therm_cfg_reg;
  reg  [1:0]             spread_reg;
  reg  [7:0]             chan_drv_reg;
  reg  [`EV_W-1:0]       irq_stat_next;
  reg  [7:0]             rdata_next;
  wire                   run;
  wire                   hard_rst;
  wire                   hotplug_n;
  wire                   therm_n;
  wire                   pgood;
  wire                   hotplug_ev;
  wire                   therm_ev;
  wire                   msg_fire;

  assign pgood      = misc_sync[4];
  assign hard_rst   = ~misc_sync[3];
  assign hotplug_n  = misc_sync[1];
  assign therm_n    = misc_sync[0];
  assign run        = pgood & ~hard_rst;
  assign hotplug_ev = run & hotplug_q_reg & ~hotplug_n;
  assign therm_ev   = run & therm_q_reg & ~therm_n;
  assign msg_fire   = therm_ev & therm_cfg_reg[`THERM_EN_BIT];

  // Every pin group crosses through two flops; only the line release also reads I_PRIMARY_RESET_N bare
  sideband_sync2 #(
    .WIDTH     (8),
    .RESET_VAL (`STRAP_SYNC_RESET)
  ) i_strap_sync (
    .i_clk     (I_MCLK),
    .i_reset_n (I_RESET_N),
    .i_d       (I_ADDIN_IDENT_STRAP),
    .o_q       (strap_sync)
  );

  // Starts as power not good and hard reset held, with event pins idle high
  sideband_sync2 #(
    .WIDTH     (5),
    .RESET_VAL (`MISC_SYNC_RESET)
  ) i_misc_sync (
    .i_clk     (I_MCLK),
    .i_reset_n (I_RESET_N),
    .i_d       ({I_POWER_GOOD, I_PRIMARY_RESET_N, I_VIDEO_DEVICE_PRESENT_N,
                 I_DISPLAY_HOTPLUG_IRQ_N, I_EXT_THERMAL_ALERT_N}),
    .o_q       (misc_sync)
  );

  // Released lines read high, so the line history starts high
  sideband_sync2 #(
    .WIDTH     (8),
    .RESET_VAL (`LINE_SYNC_RESET)
  ) i_line_sync (
    .i_clk     (I_MCLK),
    .i_reset_n (I_RESET_N),
    .i_d       ({I_CHAN_DAT, I_CHAN_CLK}),
    .o_q       (chin_sync)
  );

  // Straps caught once, on the first clean cycle after primary reset release
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ident_reg         <= 8'h00;
      present_reg       <= 1'b0;
      latched_reg       <= 1'b0;
      O_NATIVE_GFX_MODE <= 1'b0;
    end else if (hard_rst) begin
      latched_reg       <= 1'b0;
      O_NATIVE_GFX_MODE <= 1'b0;
    end else if (!latched_reg && pgood) begin
      latched_reg       <= 1'b1;
      ident_reg         <= strap_sync;
      present_reg       <= ~misc_sync[2];
      O_NATIVE_GFX_MODE <= strap_sync[0];
    end
  end

  // Event edge history; a level held low raises one event only
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      hotplug_q_reg <= 1'b1;
      therm_q_reg   <= 1'b1;
    end else begin
      hotplug_q_reg <= hotplug_n;
      therm_q_reg   <= therm_n;
    end
  end

  // Sticky status: a set in the clearing cycle wins
  always @* begin
    irq_stat_next = irq_stat_reg;
    if (I_WR && I_ADDR == `OFS_IRQ_STAT) begin
      irq_stat_next = irq_stat_next & ~I_WDATA[`EV_W-1:0];
    end
    irq_stat_next[`EV_HOTPLUG] = irq_stat_next[`EV_HOTPLUG] | hotplug_ev;
    irq_stat_next[`EV_THERMAL] = irq_stat_next[`EV_THERMAL] | therm_ev;
  end

  // Software registers
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      irq_stat_reg  <= {`EV_W{1'b0}};
      irq_mask_reg  <= `MASK_RESET;
      therm_cfg_reg <= `THERM_CFG_RESET;
      spread_reg    <= 2'h0;
      chan_drv_reg  <= 8'h00;
    end else if (hard_rst) begin
      irq_stat_reg  <= {`EV_W{1'b0}};
      chan_drv_reg  <= 8'h00;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (I_WR) begin
        case (I_ADDR)
          `OFS_IRQ_MASK:   irq_mask_reg  <= I_WDATA[`EV_W-1:0];
          `OFS_THERM_CFG:  therm_cfg_reg <= I_WDATA[2:0];
          `OFS_SPREAD_CTL: spread_reg    <= I_WDATA[1:0];
          `OFS_CHAN_OUT:   chan_drv_reg  <= I_WDATA;
          default:         spread_reg    <= spread_reg;
        endcase
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always @* begin
    case (I_ADDR)
      `OFS_STRAP:      rdata_next = ident_reg;
      `OFS_STATUS:     rdata_next = {3'h0, latched_reg, O_NATIVE_GFX_MODE,
                                     O_READ_THROTTLE, present_reg, run};
      `OFS_IRQ_STAT:   rdata_next = {6'h00, irq_stat_reg};
      `OFS_IRQ_MASK:   rdata_next = {6'h00, irq_mask_reg};
      `OFS_THERM_CFG:  rdata_next = {5'h00, therm_cfg_reg};
      `OFS_SPREAD_CTL: rdata_next = {6'h00, spread_reg};
      `OFS_CHAN_OUT:   rdata_next = chan_drv_reg;
      `OFS_CHAN_IN:    rdata_next = chin_sync;
      default:         rdata_next = 8'h00;
    endcase
  end

  // Read data stands for the one cycle after the read strobe, zero otherwise
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_RDATA <= 8'h00;
    end else begin
      O_RDATA <= I_RD ? rdata_next : 8'h00;
    end
  end

  // Interrupt looks at the next status so a new event is not a cycle late
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // Throttle follows the alert level while powered and out of reset
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_READ_THROTTLE <= 1'b0;
    end else begin
      O_READ_THROTTLE <= run & ~therm_n;
    end
  end

  // One-cycle message pulse, routed by the selector; code 3 sends nothing
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_SYSTEM_ERROR_MSG   <= 1'b0;
      O_CONTROL_IRQ_MSG    <= 1'b0;
      O_MANAGEMENT_IRQ_MSG <= 1'b0;
    end else begin
      O_SYSTEM_ERROR_MSG   <= msg_fire & (therm_cfg_reg[1:0] == `MSG_SYSERR);
      O_CONTROL_IRQ_MSG    <= msg_fire & (therm_cfg_reg[1:0] == `MSG_CTLIRQ);
      O_MANAGEMENT_IRQ_MSG <= msg_fire & (therm_cfg_reg[1:0] == `MSG_MGMTIRQ);
    end
  end

  // Spread-spectrum chip controls are plain levels copied from software
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_SPREAD_CLK_CTL  <= 1'b0;
      O_SPREAD_DATA_CTL <= 1'b0;
    end else begin
      O_SPREAD_CLK_CTL  <= spread_reg[0];
      O_SPREAD_DATA_CTL <= spread_reg[1];
    end
  end

  // Open drain: drive low only. The bare reset pin also releases the lines,
  // so they let go one edge into hard reset rather than after the synchroniser
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_CHAN_CLK    <= 4'h0;
      O_CHAN_DAT    <= 4'h0;
      O_CHAN_CLK_OE <= 4'h0;
      O_CHAN_DAT_OE <= 4'h0;
    end else begin
      O_CHAN_CLK    <= 4'h0;
      O_CHAN_DAT    <= 4'h0;
      if (hard_rst || !I_PRIMARY_RESET_N) begin
        O_CHAN_CLK_OE <= 4'h0;
        O_CHAN_DAT_OE <= 4'h0;
      end else begin
        O_CHAN_CLK_OE <= chan_drv_reg[3:0];
        O_CHAN_DAT_OE <= chan_drv_reg[7:4];
      end
    end
  end

endmodule

// Two-flop synchroniser; only the second stage is visible outside
module sideband_sync2 #(
  parameter             WIDTH     = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_reset_n,
  // Data
  input  wire [WIDTH-1:0] i_d,
  output reg  [WIDTH-1:0] o_q
);

  reg  [WIDTH-1:0] stage1_reg;

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stage1_reg <= RESET_VAL;
      o_q        <= RESET_VAL;
    end else begin
      stage1_reg <= i_d;
      o_q        <= stage1_reg;
    end
  end

endmodule
`default_nettype wire

/* sideband_checker_asserts.sv */
// Purpose: Port-level checks for the display sideband block
// Assumes: One core clock, asynchronous active-low reset
// Notes:   Windows of five edges cover the two-flop input path plus the output flop
`timescale 1ns/10ps
`default_nettype none
module sideband_checker (
  input wire logic       I_MCLK, I_RESET_N, I_PRIMARY_RESET_N, I_POWER_GOOD, I_RD,
  input wire logic       I_EXT_THERMAL_ALERT_N, O_READ_THROTTLE, O_IRQ,
  input wire logic       O_SYSTEM_ERROR_MSG, O_CONTROL_IRQ_MSG, O_MANAGEMENT_IRQ_MSG,
  input wire logic [7:0] O_RDATA,
  input wire logic [3:0] O_CHAN_CLK, O_CHAN_DAT, O_CHAN_CLK_OE, O_CHAN_DAT_OE
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);
  wire logic [2:0] msg = {O_SYSTEM_ERROR_MSG, O_CONTROL_IRQ_MSG, O_MANAGEMENT_IRQ_MSG};
  wire logic       live = I_POWER_GOOD && I_PRIMARY_RESET_N;
  AST_MSG_ONE: assert property ($onehot0(msg)) else $error("two messages at once");
  AST_MSG_PULSE: assert property (|msg |=> msg == 3'h0) else $error("message too long");
  AST_MSG_IDLE: assert property (I_EXT_THERMAL_ALERT_N [*5] |-> msg == 3'h0)
    else $error("message without alert");
  AST_THR_OFF: assert property (I_EXT_THERMAL_ALERT_N [*5] |-> !O_READ_THROTTLE)
    else $error("throttle without alert");
  AST_THR_ON: assert property ((!I_EXT_THERMAL_ALERT_N && live) [*5] |-> O_READ_THROTTLE)
    else $error("alert did not throttle");
  AST_PGOOD_OFF: assert property (!I_POWER_GOOD [*5] |-> !O_READ_THROTTLE && msg == 3'h0)
    else $error("activity without power good");
  AST_OE_RESET: assert property (!I_PRIMARY_RESET_N [*2] |-> {O_CHAN_CLK_OE, O_CHAN_DAT_OE} == 8'h00)
    else $error("line driven in hard reset");
  AST_OPEN_DRAIN: assert property ({O_CHAN_CLK, O_CHAN_DAT} == 8'h00)
    else $error("line driven high");
  AST_RDATA_IDLE: assert property (!I_RD |=> O_RDATA == 8'h00) else $error("stale read data");
  cover property ($rose(O_READ_THROTTLE));
  cover property (O_MANAGEMENT_IRQ_MSG);
  cover property ($rose(O_IRQ));
endmodule
bind display_sideband_strap_logic sideband_checker i_sideband_checker (.*);
`default_nettype wire

/* sideband_far_side.sv */
// Purpose: Board, encoder, monitor and thermal sensor beside the block
// Assumes: Lines have pull-ups; no party drives a line high
// Notes:   Spare strap pins read high as if left unconnected
`timescale 1ns/10ps
`default_nettype none
module sideband_far_side (
  input  wire logic       no_onboard_dev,
  input  wire logic       hp_assert,
  input  wire logic       alert_assert,
  input  wire logic [3:0] clk_oe,
  input  wire logic [3:0] dat_oe,
  output wire logic [7:0] strap,
  output wire logic       present_n,
  output wire logic       hotplug_n,
  output wire logic       alert_n,
  output wire logic [3:0] clk_line,
  output wire logic [3:0] dat_line
);
  assign strap     = no_onboard_dev ? 8'hff : 8'h7f;
  assign present_n = no_onboard_dev;
  assign hotplug_n = !hp_assert;
  assign alert_n   = !alert_assert;
  assign clk_line  = ~clk_oe;
  assign dat_line  = ~dat_oe;
endmodule
`default_nettype wire

/* testbench.sv */
// Purpose: Register-level tests of straps, events, throttle and lines
// Assumes: Board straps 8'h7f with the video device present, later a board without it
// Notes:   Event latency is three edges, so windows of six cycles are used
`timescale 1ns/10ps
`include "sideband_defines.vh"
`default_nettype none
module testbench;
  logic I_MCLK = 0, I_RESET_N = 0, I_PRIMARY_RESET_N = 1, I_POWER_GOOD = 1, I_WR = 0, I_RD = 0;
  logic [`ADDR_W-1:0] I_ADDR = 0;
  logic [7:0] I_WDATA = 8'h00, O_RDATA, I_ADDIN_IDENT_STRAP;
  logic I_VIDEO_DEVICE_PRESENT_N, I_DISPLAY_HOTPLUG_IRQ_N, I_EXT_THERMAL_ALERT_N, O_IRQ;
  logic O_READ_THROTTLE, O_NATIVE_GFX_MODE, O_SYSTEM_ERROR_MSG, O_CONTROL_IRQ_MSG;
  logic O_MANAGEMENT_IRQ_MSG, O_SPREAD_CLK_CTL, O_SPREAD_DATA_CTL, hp = 0, th = 0, nb = 0;
  logic [3:0] I_CHAN_CLK, I_CHAN_DAT, O_CHAN_CLK, O_CHAN_DAT, O_CHAN_CLK_OE, O_CHAN_DAT_OE;
  logic [2:0] m;
  int miscompares = 0, num_checks = 0, n;
  display_sideband_strap_logic i_display_sideband_strap_logic (.*);
  sideband_far_side i_sideband_far_side (.no_onboard_dev(nb), .hp_assert(hp), .alert_assert(th),
    .clk_oe(O_CHAN_CLK_OE), .dat_oe(O_CHAN_DAT_OE), .strap(I_ADDIN_IDENT_STRAP),
    .present_n(I_VIDEO_DEVICE_PRESENT_N), .hotplug_n(I_DISPLAY_HOTPLUG_IRQ_N),
    .alert_n(I_EXT_THERMAL_ALERT_N), .clk_line(I_CHAN_CLK), .dat_line(I_CHAN_DAT));
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge I_MCLK);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge I_MCLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_MCLK);
    I_WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge I_MCLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_MCLK);
    I_RD <= 1'b0;
    #1 chk(what, O_RDATA, exp);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    forever #12.5 I_MCLK = ~I_MCLK;
  end
  initial begin
    #100000;
    miscompares++;
    conclude;
  end
  initial begin
    repeat (3) @(posedge I_MCLK);
    I_RESET_N <= 1'b1;
    cyc(8);
    rd(`OFS_STRAP, 8'h7f, "strap");
    rd(`OFS_STATUS, 8'h1b, "status");
    chk("native", {7'h00, O_NATIVE_GFX_MODE}, 8'h01);
    rd(4'h9, 8'h00, "unmapped");
    $display("straps done");
    wr(`OFS_IRQ_MASK, 8'h00);
    hp <= 1'b1;
    cyc(6);
    chk("irq masked", {7'h00, O_IRQ}, 8'h00);
    rd(`OFS_IRQ_STAT, 8'h01, "hotplug stat");
    wr(`OFS_IRQ_MASK, 8'h03);
    cyc(2);
    chk("irq", {7'h00, O_IRQ}, 8'h01);
    wr(`OFS_IRQ_STAT, 8'h01);
    hp <= 1'b0;
    cyc(2);
    chk("irq clear", {7'h00, O_IRQ}, 8'h00);
    $display("hotplug done");
    for (int s = 0; s < 4; s++) begin
      wr(`OFS_THERM_CFG, 8'h04 | s[7:0]);
      th <= 1'b1;
      m = 3'h0;
      n = 0;
      repeat (8) begin
        cyc(1);
        m |= {O_SYSTEM_ERROR_MSG, O_CONTROL_IRQ_MSG, O_MANAGEMENT_IRQ_MSG};
        n += (O_SYSTEM_ERROR_MSG | O_CONTROL_IRQ_MSG | O_MANAGEMENT_IRQ_MSG) === 1'b1;
      end
      chk("message", {5'h00, m}, 8'h04 >> s);
      chk("pulses", n[7:0], (s < 3) ? 8'h01 : 8'h00);
      chk("throttle", {7'h00, O_READ_THROTTLE}, 8'h01);
      th <= 1'b0;
      cyc(6);
      chk("throttle off", {7'h00, O_READ_THROTTLE}, 8'h00);
      chk("thermal irq", {7'h00, O_IRQ}, 8'h01);
      rd(`OFS_IRQ_STAT, 8'h02, "thermal stat");
      wr(`OFS_IRQ_STAT, 8'h02);
    end
    $display("thermal done");
    wr(`OFS_SPREAD_CTL, 8'h02);
    wr(`OFS_CHAN_OUT, 8'h5a);
    cyc(5);
    chk("spread", {6'h00, O_SPREAD_DATA_CTL, O_SPREAD_CLK_CTL}, 8'h02);
    chk("line drive", {O_CHAN_DAT_OE, O_CHAN_CLK_OE}, 8'h5a);
    rd(`OFS_CHAN_IN, 8'ha5, "lines");
    $display("pins done");
    I_PRIMARY_RESET_N <= 1'b0;
    th <= 1'b1;
    nb <= 1'b1;
    cyc(6);
    chk("hard reset lines", {O_CHAN_DAT_OE, O_CHAN_CLK_OE}, 8'h00);
    chk("throttle in reset", {7'h00, O_READ_THROTTLE}, 8'h00);
    I_PRIMARY_RESET_N <= 1'b1;
    I_POWER_GOOD <= 1'b0;
    cyc(6);
    chk("throttle no power", {7'h00, O_READ_THROTTLE}, 8'h00);
    I_POWER_GOOD <= 1'b1;
    cyc(6);
    chk("throttle resumes", {7'h00, O_READ_THROTTLE}, 8'h01);
    rd(`OFS_STATUS, 8'h1d, "status relatched");
    rd(`OFS_STRAP, 8'hff, "strap relatched");
    th <= 1'b0;
    $display("reset done");
    conclude;
  end
endmodule
`default_nettype wire
